// ### verilog/wdt_top.sv
// Purpose: Watchdog timer with mode select, period select and Wishbone regs
// Assumes: Single 200 MHz clock; oscillator edges arrive as a strobe
// Notes: Time-out awake resets the device; time-out in sleep wakes it
//
// Functional notes
// - Count on the 31 kHz low oscillator using a 1 ms base tick.
// - A two-bit nonvolatile mode select chooses one of four modes.
// - Mode 11: always active, sleep included, software enable ignored.
// - Mode 10: active while awake, disabled during sleep.
// - Mode 01: active only while software enable is set; sleep irrelevant.
// - Mode 00: disabled, software enable ignored.
// - Five-bit period select chooses time-out from 1 ms upward.
// - After reset the period select gives about two seconds.
// - Counter clears on reset, sleep entry, oscillator fail, disable.
// - The clear instruction clears the counter.
// - Wake from sleep by interrupt clears the counter.
// - Counter held clear while the oscillator start-up timer runs.
// - Time-out in sleep wakes device and updates timeout and powerdown.
// - On sleep exit clear again and hold until start-up timer ends.
// - Clock switch or divider change leaves the counter unaffected.
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module wdt_top #(
  parameter int unsigned CNT_WIDTH = wdt_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic reset,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core and system inputs
  input wire logic [1:0] watchdog_mode_select,
  input wire logic low_freq_internal_osc_edge,
  input wire logic sleep_active,
  input wire logic wake_interrupt,
  input wire logic osc_fail,
  input wire logic oscillator_startup_timer_busy,
  input wire logic watchdog_clear_instruction,
  input wire logic clock_switch,
  input wire logic por_event,
  // Outputs
  output logic device_reset,
  output logic wake_request,
  output logic timeout_status_flag,
  output logic powerdown_status_flag
);
  import wdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic software_watchdog_enable_r;
    logic [PS_W-1:0] timeout_period_select_r;
    logic [CNT_WIDTH-1:0] watchdog_counter_r;
    logic sleep_d_r;
    logic exit_hold_r;
    logic to_r;
    logic pd_r;
    logic rst_r;
    logic wake_r;
    logic ack_r;
    logic [31:0] dat_r;
  } wdt_st_t;

  wdt_st_t s_r, s_nxt;

  logic tick;
  logic active;
  logic clr_cond;
  logic [CNT_WIDTH-1:0] limit;
  logic wb_req;
  logic wr_hit_ctrl;
  logic wr_hit_clr;
  logic sw_clear;
  logic [PS_W-1:0] ps_eff;

  ////////////////////////////////////////////////////////////////////////////

  // Tick counts only while the counter may run, so the first ms is whole
  wdt_tick i_wdt_tick (
    .clk(clk),
    .reset(reset),
    .osc_edge(low_freq_internal_osc_edge),
    .hold(clr_cond),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    active = 1'b0;
    unique case (wdt_mode_t'(watchdog_mode_select))
      WDT_MODE_ON: active = 1'b1;
      WDT_MODE_NOSLEEP: active = !sleep_active;
      WDT_MODE_SW: active = s_r.software_watchdog_enable_r;
      WDT_MODE_OFF: active = 1'b0;
    endcase
  end

  assign wb_req = wb_cyc_i && wb_stb_i && !s_r.ack_r;
  assign wr_hit_ctrl = wb_req && wb_we_i && (wb_adr_i == WDT_CTRL_OFS)
    && wb_sel_i[0];
  assign wr_hit_clr = wb_req && wb_we_i && (wb_adr_i == WDT_CLR_OFS)
    && wb_sel_i[0] && (wb_dat_i[7:0] == CLR_KEY);
  assign sw_clear = watchdog_clear_instruction || wr_hit_clr;

  // Clock switch is deliberately absent from the clear terms
  assign clr_cond = !active
    || osc_fail
    || (sleep_active && !s_r.sleep_d_r)
    || (!sleep_active && s_r.sleep_d_r)
    || wake_interrupt
    || oscillator_startup_timer_busy
    || s_r.exit_hold_r
    || sw_clear;

  // Codes above the top step saturate at the longest period
  assign ps_eff = (s_r.timeout_period_select_r > PS_MAX) ? PS_MAX
    : s_r.timeout_period_select_r;
  assign limit = CNT_WIDTH'(1) << ps_eff;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_r = 1'b0;
    s_nxt.wake_r = 1'b0;
    s_nxt.ack_r = 1'b0;
    s_nxt.sleep_d_r = sleep_active;

    // Hold after sleep exit until the start-up timer has finished
    if (!sleep_active && s_r.sleep_d_r) begin
      s_nxt.exit_hold_r = 1'b1;
    end else if (!oscillator_startup_timer_busy) begin
      s_nxt.exit_hold_r = 1'b0;
    end

    if (clr_cond) begin
      s_nxt.watchdog_counter_r = '0;
    end else if (tick) begin
      if (s_r.watchdog_counter_r + CNT_WIDTH'(1) >= limit) begin
        s_nxt.watchdog_counter_r = '0;
        s_nxt.to_r = 1'b0;
        if (sleep_active) begin
          s_nxt.wake_r = 1'b1;
          s_nxt.pd_r = 1'b0;
        end else begin
          s_nxt.rst_r = 1'b1;
        end
      end else begin
        s_nxt.watchdog_counter_r = s_r.watchdog_counter_r + CNT_WIDTH'(1);
      end
    end

    // Clear instruction sets both flags; sleep entry clears powerdown
    if (sw_clear && !(tick && !clr_cond)) begin
      s_nxt.to_r = 1'b1;
      s_nxt.pd_r = 1'b1;
    end
    if (sleep_active && !s_r.sleep_d_r) begin
      s_nxt.to_r = 1'b1;
      s_nxt.pd_r = 1'b0;
    end
    if (por_event) begin
      s_nxt.to_r = 1'b1;
      s_nxt.pd_r = 1'b1;
    end

    if (wr_hit_ctrl) begin
      s_nxt.software_watchdog_enable_r = wb_dat_i[CTRL_EN_BIT];
      s_nxt.timeout_period_select_r = wb_dat_i[CTRL_PS_LSB +: PS_W];
    end

    if (wb_req) begin
      s_nxt.ack_r = 1'b1;
      s_nxt.dat_r = '0;
      if (!wb_we_i) begin
        unique case (wb_adr_i)
          WDT_CTRL_OFS: begin
            s_nxt.dat_r[CTRL_EN_BIT] = s_r.software_watchdog_enable_r;
            s_nxt.dat_r[CTRL_PS_LSB +: PS_W] = s_r.timeout_period_select_r;
          end
          WDT_STAT_OFS: begin
            s_nxt.dat_r[STAT_TO_BIT] = s_r.to_r;
            s_nxt.dat_r[STAT_PD_BIT] = s_r.pd_r;
            s_nxt.dat_r[STAT_ACT_BIT] = active;
            s_nxt.dat_r[STAT_CLR_BIT] = clr_cond;
          end
          default: s_nxt.dat_r = '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.timeout_period_select_r <= PS_RESET;
      s_r.to_r <= 1'b1;
      s_r.pd_r <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.dat_r;
  assign wb_ack_o = s_r.ack_r;
  assign device_reset = s_r.rst_r;
  assign wake_request = s_r.wake_r;
  assign timeout_status_flag = s_r.to_r;
  assign powerdown_status_flag = s_r.pd_r;

endmodule

// ### verilog/wdt_pkg.sv
// Purpose: Shared constants for the watchdog timer block
// Assumes: 200 MHz system clock, 31 kHz low-frequency oscillator
// Notes: Register map, field positions, reset values and time bases
package wdt_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned LFOSC_HZ = 31_000;
  localparam int unsigned BASE_TICK_US = 1_000;
  // Oscillator cycles per 1 ms base tick, rounded down
  localparam int unsigned LFOSC_PER_TICK = LFOSC_HZ * BASE_TICK_US / 1_000_000;

  // Register offsets (byte addresses)
  localparam logic [3:0] WDT_CTRL_OFS = 4'h0;
  localparam logic [3:0] WDT_STAT_OFS = 4'h4;
  localparam logic [3:0] WDT_CLR_OFS = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_PS_LSB = 1;
  localparam int unsigned PS_W = 5;
  // 2**11 ms is about two seconds
  localparam logic [4:0] PS_RESET = 5'h0B;
  localparam logic [4:0] PS_MAX = 5'h12;

  // Status register fields
  localparam int unsigned STAT_TO_BIT = 0;
  localparam int unsigned STAT_PD_BIT = 1;
  localparam int unsigned STAT_ACT_BIT = 2;
  localparam int unsigned STAT_CLR_BIT = 3;

  // Clear command key (low byte of a write to the clear register)
  localparam logic [7:0] CLR_KEY = 8'hA5;

  localparam int unsigned CNT_W = 19;

  typedef enum logic [1:0] {
    WDT_MODE_OFF = 2'h0,
    WDT_MODE_SW = 2'h1,
    WDT_MODE_NOSLEEP = 2'h2,
    WDT_MODE_ON = 2'h3
  } wdt_mode_t;

endpackage

// ### verilog/wdt_tick.sv
// Purpose: Base tick generator on the low-frequency oscillator
// Assumes: Oscillator enable is synchronous to clk
// Notes: Emits one pulse per nominal 1 ms
`timescale 1ns/10ps
module wdt_tick #(
  parameter int unsigned DIV = wdt_pkg::LFOSC_PER_TICK
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic osc_edge,
  input wire logic hold,
  output logic tick
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [15:0] div_r;
    logic tick_r;
  } wdt_tick_st_t;

  wdt_tick_st_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick_r = 1'b0;
    if (hold) begin
      s_nxt.div_r = '0;
    end else if (osc_edge) begin
      if (s_r.div_r == 16'(DIV - 1)) begin
        s_nxt.div_r = '0;
        s_nxt.tick_r = 1'b1;
      end else begin
        s_nxt.div_r = s_r.div_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick_r;

endmodule

// ### sim/wdt_monitor.sv
// Purpose: Port checker for wdt_top
// Assumes: One clock, synchronous reset
// Notes: Bound to every wdt_top
`timescale 1ns/10ps
module wdt_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] watchdog_mode_select,
  input wire logic sleep_active,
  input wire logic osc_fail,
  input wire logic oscillator_startup_timer_busy,
  input wire logic watchdog_clear_instruction,
  input wire logic device_reset,
  input wire logic wake_request,
  input wire logic timeout_status_flag,
  input wire logic powerdown_status_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic hit = device_reset | wake_request;
  ////////////////////////////////////////
  property p_rst; disable iff (1'b0)
    reset |=> !hit && timeout_status_flag && powerdown_status_flag;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_off; $past(watchdog_mode_select) == 2'h0
    && $past(watchdog_mode_select, 2) == 2'h0 |-> !hit;
  endproperty
  a_off: assert property (p_off) else $error("off fired");
  property p_slp; $past(watchdog_mode_select) == 2'h2
    && $past(sleep_active) && $past(sleep_active, 2) |-> !wake_request;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep fired");
  property p_fail; $past(osc_fail) |-> !hit; endproperty
  a_fail: assert property (p_fail) else $error("fail fired");
  property p_ost; $past(oscillator_startup_timer_busy) |-> !hit; endproperty
  a_ost: assert property (p_ost) else $error("ost fired");
  property p_clr; watchdog_clear_instruction |=> !hit; endproperty
  a_clr: assert property (p_clr) else $error("clear fired");
  property p_rsto; device_reset |-> !$past(sleep_active)
    ##1 (!device_reset && !timeout_status_flag);
  endproperty
  a_rsto: assert property (p_rsto) else $error("reset pulse");
  property p_wake; wake_request |-> $past(sleep_active) ##1 (!wake_request
    && !timeout_status_flag && !powerdown_status_flag);
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse");
  c_rst: cover property (device_reset);
  c_wake: cover property (wake_request);
  c_clr: cover property (watchdog_clear_instruction);
endmodule
bind wdt_top wdt_monitor i_wdt_monitor (.clk, .reset,
  .watchdog_mode_select, .sleep_active, .osc_fail,
  .oscillator_startup_timer_busy, .watchdog_clear_instruction,
  .device_reset, .wake_request, .timeout_status_flag, .powerdown_status_flag);

// ### sim/wdt_top_test.sv
// Purpose: Self-checking bench for wdt_top
// Assumes: Osc strobe every other clock, so one tick is 62 clocks
// Notes: Small period codes keep the run short
`timescale 1ns/10ps
module wdt_top_test;
  import wdt_pkg::*;
  logic clk = 0, reset = 1, cyc = 0, we = 0, osc = 0, slp = 0, fail = 0;
  logic oscillator_startup_timer = 0, clr = 0, wint = 0, ack, dr, wr, tof, pdf;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rd, q;
  logic [1:0] mode = 2'h3, got;
  // Bits: mode, enable, sleep, osc fail, start-up busy, expected pulse
  logic [7:0] tbl [9] = '{8'h20, 8'h40, 8'h72, 8'h81, 8'h90, 8'hD2,
    8'h61, 8'hC8, 8'hC4};
  int n, i, n_errors = 0, check_count = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) osc <= ~osc;
  ////////////////////////////////////////
  wdt_top i_wdt_top (.clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .watchdog_mode_select(mode),
    .low_freq_internal_osc_edge(osc), .sleep_active(slp),
    .wake_interrupt(wint), .osc_fail(fail), .clock_switch(osc),
    .oscillator_startup_timer_busy(oscillator_startup_timer), .por_event(1'b0),
    .watchdog_clear_instruction(clr), .device_reset(dr),
    .wake_request(wr), .timeout_status_flag(tof),
    .powerdown_status_flag(pdf));
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    cyc <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rd;
    cyc <= 0;
    @(posedge clk);
    chk(i < 20, 1);
    if (i == 20) wrap_up();
  endtask
  // Sleep is entered a cycle after the clear so their flag updates differ
  task automatic go(input logic [7:0] t, input logic [4:0] p, input int lim);
    mode <= t[7:6];
    fail <= t[3];
    oscillator_startup_timer <= t[2];
    slp <= 0;
    wb(1, WDT_CTRL_OFS, {26'h0, p, t[5]});
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    slp <= t[4];
    watch(lim);
  endtask
  task automatic watch(input int lim);
    got = 0;
    for (n = 0; n < lim && got == 0; n++) begin
      @(posedge clk);
      got = {wr, dr};
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    wb(0, WDT_CTRL_OFS, 32'h0);
    chk(q, {26'h0, PS_RESET, 1'b0});
    wb(0, 4'hC, 32'h0);
    chk(q, 32'h0);
    for (int p = 1; p < 5; p++) begin
      go(8'hC0, p[4:0], 2000);
      chk(got, 2'b01);
      chk(n > 62*((1<<p)-1) && n < (62<<p)+8, 1);
      @(posedge clk);
      chk({pdf, tof}, 2'b10);
    end
    foreach (tbl[k]) begin
      go(tbl[k], 5'h0, 300);
      chk(got, tbl[k][1:0]);
    end
    repeat (4) begin
      go(8'hC0, 5'h2, 150);
      chk(got, 2'b00);
    end
    // Each clear lands before the two-tick time-out would expire
    go(8'hC0, 5'h1, 90);
    chk(got, 2'b00);
    wint <= 1;
    @(posedge clk);
    wint <= 0;
    watch(90);
    chk(got, 2'b00);
    wb(1, WDT_CLR_OFS, {24'h0, CLR_KEY});
    watch(90);
    chk(got, 2'b00);
    watch(200);
    chk(got, 2'b01);
    wb(0, WDT_STAT_OFS, 32'h0);
    chk(q, 32'h6);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    wb(0, WDT_CTRL_OFS, 32'h0);
    chk(q, {26'h0, PS_RESET, 1'b0});
    wrap_up();
  end
endmodule
